// >>> include/flags_consts.svh
// Offsets, field positions, reset values and timing counts of the flag bank.
// Assumes inclusion by bare name from design and testbench files.
`ifndef FLAGS_CONSTS_SVH
`define FLAGS_CONSTS_SVH
`define ADDR_SUPPLY_A       7'h40
`define ADDR_SUPPLY_B       7'h41
`define ADDR_THERMAL        7'h42
`define ADDR_LOWER_LIMIT    7'h3F
`define RST_SUPPLY_A        8'h00
`define RST_SUPPLY_B_POR    8'h80
`define RST_SUPPLY_B_SOFT   8'h00
`define RST_THERMAL         8'h00
`define RST_LOWER_LIMIT     8'h98
`define MASK_SUPPLY_A       8'h5F
`define MASK_SUPPLY_B       8'hFF
`define MASK_THERMAL        8'h07
`define POS_MODE_BIT        7
`define POS_DATA_LSB        8
`define FRAME_BITS          16
`define SHORT_TIME_MS       4
`define CLK_MHZ             125
`define SHORT_CYCLES        (`SHORT_TIME_MS * 1000 * `CLK_MHZ)
`endif

// >>> include/flags_pkg.sv
// Types shared by the flag bank.
// Assumes flags_consts.svh on the include path.
package flags_pkg;
   typedef enum logic [4:0] {
      MODE_INIT    = 5'h01,
      MODE_NORMAL  = 5'h02,
      MODE_STOP    = 5'h04,
      MODE_SLEEP   = 5'h08,
      MODE_RESTART = 5'h10
   } dev_mode_e;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_SHIFT = 3'h2,
      ST_DONE  = 3'h4
   } spi_state_e;

   typedef struct packed {
      logic battery_undervoltage_flag;
      logic ext_regulator_overcurrent_flag;
      logic ext_regulator_undervoltage_flag;
      logic ext_regulator_overtemp_flag;
      logic main_regulator_overvoltage_flag;
      logic main_regulator_prewarn_flag;
      logic highside_supply_undervoltage_flag;
      logic highside_supply_overvoltage_flag;
      logic aux_regulator_overtemp_flag;
      logic aux_regulator_undervoltage_flag;
      logic main_regulator_short_flag;
      logic main_undervoltage_failsafe_flag;
      logic main_regulator_undervoltage_flag;
      logic severe_thermal_shutdown_flag;
      logic first_thermal_shutdown_flag;
      logic thermal_prewarning_flag;
   } events_s;

   typedef struct packed {
      logic [2:0] sck;
      logic [1:0] cs_n;
      logic [1:0] mosi;
      logic [15:0] ev_m;
      logic [15:0] ev_s;
      logic       main_on_m;
      logic       main_on_s;
      logic       main_low_m;
      logic       main_low_s;
   } sync_s;

   typedef struct packed {
      sync_s      sy;
      spi_state_e st;
      logic [4:0] bit_cnt;
      logic [15:0] shin;
      logic [7:0] shout;
      logic       miso;
      logic [7:0] sup_a;
      logic [7:0] sup_b;
      logic [7:0] therm;
      logic [7:0] lower_limit;
      logic       reset_output_seen;
      logic [19:0] short_cnt;
      logic       short_lasting;
   } state_s;
endpackage

// >>> src/supply_thermal_flags.sv
// Sticky supply and thermal status flags with a 16-bit SPI slave port.
// Assumes analog event inputs and SPI pins are asynchronous to CLK_I.
//
// Summary of operation
// - Frame is 16 bits: address, mode, data
// - Data byte occupies frame bits 8 to 15
// - Mode bit 0 reads, flags untouched
// - Mode bit 1 clears addressed byte's flags
// - Flags stay set until cleared by SPI or soft reset
// - One data byte per 16-bit command
// - Reserved bits read zero, ignore clears
// - Supply register A flag layout at 0x40
// - Supply register B flag layout at 0x41
// - Register B: 0x80 at power-on, 0x00 soft
// - Register A and thermal reset to zero
// - Short flag after 4 ms low post switch-on
// - Failsafe flag set directly by its event input
// - Sleep with regulator off blocks three flags
// - Undervoltage flag update gated by mode
// - Thermal register layout at 0x42
// - Thermal shutdown flags stay after condition
// - Lower limit register, 8-bit read-write
// - Watchdog counter self-clears, not held here
`include "flags_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module supply_thermal_flags (
   input  wire logic                CLK_I,
   input  wire logic                RST_N_I,
   input  wire logic                SOFT_RESET_I,
   input  wire logic                SPI_SCK_I,
   input  wire logic                SPI_CS_N_I,
   input  wire logic                SPI_MOSI_I,
   input  wire flags_pkg::events_s  EVENTS_I,
   input  wire flags_pkg::dev_mode_e MODE_I,
   input  wire logic                MAIN_ON_I,
   input  wire logic                MAIN_LOW_I,
   input  wire logic                RESET_OUTPUT_RELEASED_I,
   output logic                     SPI_MISO_O,
   output logic                     SPI_MISO_OE_O,
   output logic [7:0]               RECOVERY_LOWER_LIMIT_O,
   output logic [7:0]               BIT_TIME_MEASUREMENT_O,
   input  wire logic [7:0]          BIT_TIME_RAW_I
);
   flags_pkg::state_s s_r;
   flags_pkg::state_s s_nxt;
   logic [7:0] clamp_r;
   logic [7:0] clamp_nxt;

   logic       sck_rise;
   logic       sck_fall;
   logic       cs_act;
   logic [15:0] ev;
   logic [6:0] addr;
   logic       clr_mode;
   logic       gate_main;
   logic       gate_uv;
   logic [7:0] set_a;
   logic [7:0] set_b;
   logic [7:0] set_t;
   logic [7:0] clr_a;
   logic [7:0] clr_b;
   logic [7:0] clr_t;
   logic [7:0] rd_byte;
   logic       frame_end;

   always_comb begin
      s_nxt = s_r;
      // Logic reads the last two sck stages and the second stage of the rest; first stages feed the next alone
      s_nxt.sy.sck  = {s_r.sy.sck[1:0], SPI_SCK_I};
      s_nxt.sy.cs_n = {s_r.sy.cs_n[0], SPI_CS_N_I};
      s_nxt.sy.mosi = {s_r.sy.mosi[0], SPI_MOSI_I};
      s_nxt.sy.ev_m = EVENTS_I;
      s_nxt.sy.ev_s = s_r.sy.ev_m;
      s_nxt.sy.main_on_m  = MAIN_ON_I;
      s_nxt.sy.main_on_s  = s_r.sy.main_on_m;
      s_nxt.sy.main_low_m = MAIN_LOW_I;
      s_nxt.sy.main_low_s = s_r.sy.main_low_m;
      sck_rise = s_r.sy.sck[1] & ~s_r.sy.sck[2];
      sck_fall = ~s_r.sy.sck[1] & s_r.sy.sck[2];
      cs_act   = ~s_r.sy.cs_n[1];
      ev       = s_r.sy.ev_s;
      addr     = s_r.shin[15:9];
      clr_mode = s_r.shin[8];
      frame_end = 1'b0;

      case (s_r.sy.main_on_s & s_r.sy.main_low_s)
         // 4 ms below threshold after switch-on marks a short
         1'b1: begin
            if (s_r.short_cnt != 20'(`SHORT_CYCLES)) begin
               s_nxt.short_cnt = s_r.short_cnt + 20'h00001;
            end
         end
         default: begin
            s_nxt.short_cnt = 20'h00000;
         end
      endcase
      s_nxt.short_lasting = (s_r.short_cnt == 20'(`SHORT_CYCLES));

      if (RESET_OUTPUT_RELEASED_I && MODE_I == flags_pkg::MODE_INIT) begin
         s_nxt.reset_output_seen = 1'b1;
      end
      if (MODE_I == flags_pkg::MODE_RESTART) begin
         s_nxt.reset_output_seen = 1'b0;
      end

      gate_main = ~(MODE_I == flags_pkg::MODE_SLEEP && !s_r.sy.main_on_s);
      case (MODE_I)
         flags_pkg::MODE_RESTART: gate_uv = 1'b0;
         flags_pkg::MODE_INIT:    gate_uv = s_r.reset_output_seen;
         flags_pkg::MODE_NORMAL,
         flags_pkg::MODE_STOP:    gate_uv = 1'b1;
         default:                 gate_uv = 1'b0;
      endcase
      gate_uv = (gate_uv | s_r.short_lasting) & gate_main;

      // Bit order follows the register layout; reserved positions held at 0
      set_a = {1'b0, ev[15], 1'b0, ev[14], ev[13], ev[12],
               ev[11] & gate_main, ev[10]};
      // Short flag from its comparator event or from the own 4 ms count
      set_b = {1'b0, ev[9], ev[8], ev[7], ev[6],
               (s_r.short_lasting | ev[5]) & gate_main, ev[4],
               ev[3] & gate_uv};
      set_t = {5'h00, ev[2], ev[1], ev[0]};

      // SPI shift: MSB first, sample on rising, drive on falling edge
      clr_a = 8'h00;
      clr_b = 8'h00;
      clr_t = 8'h00;
      case (s_r.st)
         flags_pkg::ST_IDLE: begin
            s_nxt.bit_cnt = 5'h00;
            if (cs_act) begin
               s_nxt.st = flags_pkg::ST_SHIFT;
            end
         end
         flags_pkg::ST_SHIFT: begin
            if (!cs_act) begin
               s_nxt.st = flags_pkg::ST_IDLE; // Short frame dropped
            end else if (sck_rise) begin
               s_nxt.shin = {s_r.shin[14:0], s_r.sy.mosi[1]};
               s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
               if (s_r.bit_cnt == 5'h07) begin
                  s_nxt.shout = rd_byte;
               end
            end else if (sck_fall && s_r.bit_cnt >= 5'h08) begin
               s_nxt.miso  = s_r.shout[7];
               s_nxt.shout = {s_r.shout[6:0], 1'b0};
            end
            if (s_r.bit_cnt == 5'(`FRAME_BITS) && !cs_act) begin
               frame_end = 1'b1;
            end
         end
         default: s_nxt.st = flags_pkg::ST_IDLE;
      endcase
      if (frame_end) begin
         s_nxt.st = flags_pkg::ST_IDLE;
      end

      if (frame_end && clr_mode) begin
         case (addr)
            `ADDR_SUPPLY_A: clr_a = `MASK_SUPPLY_A;
            `ADDR_SUPPLY_B: clr_b = `MASK_SUPPLY_B;
            `ADDR_THERMAL:  clr_t = `MASK_THERMAL;
            default: ;
         endcase
      end
      if (frame_end && addr == `ADDR_LOWER_LIMIT && clr_mode) begin
         s_nxt.lower_limit = s_r.shin[7:0];
      end

      // Set wins over clear; flags only fall by SPI clear or SOFT_RESET_I
      s_nxt.sup_a = ((s_r.sup_a & ~clr_a) | set_a) & `MASK_SUPPLY_A;
      s_nxt.sup_b = (s_r.sup_b & ~clr_b) | set_b;
      s_nxt.therm = ((s_r.therm & ~clr_t) | set_t) & `MASK_THERMAL;

      if (SOFT_RESET_I) begin
         s_nxt.sup_a = `RST_SUPPLY_A;
         s_nxt.sup_b = `RST_SUPPLY_B_SOFT;
         s_nxt.therm = `RST_THERMAL;
         s_nxt.lower_limit = `RST_LOWER_LIMIT;
      end

      // Clamp low measurements to the lower limit
      clamp_nxt = (BIT_TIME_RAW_I < s_r.lower_limit) ? s_r.lower_limit
                                                      : BIT_TIME_RAW_I;
   end

   always_comb begin
      case (s_r.shin[6:0])
         `ADDR_SUPPLY_A:    rd_byte = s_r.sup_a;
         `ADDR_SUPPLY_B:    rd_byte = s_r.sup_b;
         `ADDR_THERMAL:     rd_byte = s_r.therm;
         `ADDR_LOWER_LIMIT: rd_byte = s_r.lower_limit;
         default:           rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         s_r <= '0;
         s_r.st <= flags_pkg::ST_IDLE;
         s_r.sy.sck <= 3'h0;
         s_r.sy.cs_n <= 2'h3;
         s_r.sup_a <= `RST_SUPPLY_A;
         s_r.sup_b <= `RST_SUPPLY_B_POR;
         s_r.therm <= `RST_THERMAL;
         s_r.lower_limit <= `RST_LOWER_LIMIT;
         clamp_r <= 8'h00;
      end else begin
         s_r <= s_nxt;
         clamp_r <= clamp_nxt;
      end
   end

   logic miso_oe_r;
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         miso_oe_r <= 1'b0;
      end else begin
         miso_oe_r <= ~s_r.sy.cs_n[1];
      end
   end

   assign SPI_MISO_O = s_r.miso;
   assign SPI_MISO_OE_O = miso_oe_r;
   assign RECOVERY_LOWER_LIMIT_O = s_r.lower_limit;
   assign BIT_TIME_MEASUREMENT_O = clamp_r;

   property p_reserved_zero;
      @(posedge CLK_I) disable iff (!RST_N_I)
      s_r.sup_a[7] == 1'b0 && s_r.sup_a[5] == 1'b0 && s_r.therm[7:3] == 5'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_sticky_a;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (s_r.sup_a != 8'h00 && !frame_end && !SOFT_RESET_I)
         |=> (s_r.sup_a & $past(s_r.sup_a)) == $past(s_r.sup_a);
   endproperty
   a_sticky_a: assert property (p_sticky_a) else $error("flag fell without clear");

   property p_sticky_therm;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (s_r.therm[2:1] != 2'h0 && !frame_end && !SOFT_RESET_I)
         |=> (s_r.therm[2:1] & $past(s_r.therm[2:1])) == $past(s_r.therm[2:1]);
   endproperty
   a_sticky_therm: assert property (p_sticky_therm) else $error("shutdown flag lost");

   property p_set_wins;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (ev[0] && !SOFT_RESET_I) |=> s_r.therm[0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost");

   property p_persist;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (frame_end && clr_mode && addr == `ADDR_THERMAL && ev[1] && !SOFT_RESET_I) |=> s_r.therm[1];
   endproperty
   a_persist: assert property (p_persist) else $error("persisting event lost");

   property p_clear;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (frame_end && clr_mode && addr == `ADDR_SUPPLY_A && set_a == 8'h00) |=> s_r.sup_a == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed");

   property p_read_keeps;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (frame_end && !clr_mode && !SOFT_RESET_I) |=> s_r.sup_b == ($past(s_r.sup_b) | $past(set_b));
   endproperty
   a_read_keeps: assert property (p_read_keeps) else $error("read altered flags");

   property p_soft;
      @(posedge CLK_I) disable iff (!RST_N_I)
      SOFT_RESET_I |=> s_r.sup_b == 8'h00 && s_r.sup_a == 8'h00;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset value wrong");

   property p_restart_uv;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (MODE_I == flags_pkg::MODE_RESTART && !s_r.short_lasting) |-> set_b[0] == 1'b0;
   endproperty
   a_restart_uv: assert property (p_restart_uv) else $error("uv set in restart");

   property p_short_count;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (s_r.sy.main_on_s && s_r.sy.main_low_s && s_r.short_cnt != 20'(`SHORT_CYCLES))
         |=> s_r.short_cnt == $past(s_r.short_cnt) + 20'h00001;
   endproperty
   a_short_count: assert property (p_short_count) else $error("short timer stalled");

   property p_short_idle;
      @(posedge CLK_I) disable iff (!RST_N_I)
      !(s_r.sy.main_on_s && s_r.sy.main_low_s) |=> s_r.short_cnt == 20'h00000;
   endproperty
   a_short_idle: assert property (p_short_idle) else $error("short timer held");

   property p_short_sets;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (s_r.short_lasting && gate_main && !SOFT_RESET_I) |=> s_r.sup_b[2];
   endproperty
   a_short_sets: assert property (p_short_sets) else $error("short flag missed");

   property p_sleep_block;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (MODE_I == flags_pkg::MODE_SLEEP && !s_r.sy.main_on_s)
         |-> set_b[2] == 1'b0 && set_b[0] == 1'b0 && set_a[1] == 1'b0;
   endproperty
   a_sleep_block: assert property (p_sleep_block) else $error("sleep flag set");

   property p_init_uv;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (MODE_I == flags_pkg::MODE_INIT && !s_r.reset_output_seen && !s_r.short_lasting)
         |-> set_b[0] == 1'b0;
   endproperty
   a_init_uv: assert property (p_init_uv) else $error("uv set in init");

   property p_por_flag;
      @(posedge CLK_I) disable iff (!RST_N_I)
      !s_r.sup_b[7] |=> !s_r.sup_b[7];
   endproperty
   a_por_flag: assert property (p_por_flag) else $error("power-on flag set");

   property p_refused_frame;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (s_r.st == flags_pkg::ST_SHIFT && !cs_act && s_r.bit_cnt != 5'h10 && !SOFT_RESET_I)
         |=> (s_r.therm & $past(s_r.therm)) == $past(s_r.therm);
   endproperty
   a_refused_frame: assert property (p_refused_frame) else $error("short frame acted");

   property p_limit_write;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (frame_end && clr_mode && addr == `ADDR_LOWER_LIMIT && !SOFT_RESET_I)
         |=> RECOVERY_LOWER_LIMIT_O == $past(s_r.shin[7:0]);
   endproperty
   a_limit_write: assert property (p_limit_write) else $error("limit not written");

   property p_clamp;
      @(posedge CLK_I) disable iff (!RST_N_I)
      1'b1 |=> BIT_TIME_MEASUREMENT_O >= $past(s_r.lower_limit);
   endproperty
   a_clamp: assert property (p_clamp) else $error("measurement below limit");

   property p_miso_hold;
      @(posedge CLK_I) disable iff (!RST_N_I)
      !sck_fall |=> $stable(SPI_MISO_O);
   endproperty
   a_miso_hold: assert property (p_miso_hold) else $error("data moved off fall");

   property p_oe_follows;
      @(posedge CLK_I) disable iff (!RST_N_I)
      cs_act |=> SPI_MISO_OE_O;
   endproperty
   a_oe_follows: assert property (p_oe_follows) else $error("enable missing");
endmodule
`default_nettype wire

// >>> dv/spi_master_model.sv
// Serial master model that drives the flag bank's 16-bit command port.
// Assumes mode 0, MSB first, 125 ns serial clock that runs only within frames.
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   // Fewer than 16 bits only in the refused-frame scenario
   task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] q);
      q = 8'h00;
      cs_n_o = 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         mosi_o = w[i];
         #62 sck_o = 1'b1;
         if (i < 8)
            q[i] = miso_i;
         #63 sck_o = 1'b0;
      end
      #62 cs_n_o = 1'b1;
      // Released line shows the inverse so a stale level is never mistaken
      mosi_o = ~mosi_o;
      #100;
   endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the supply and thermal flag bank.
// Assumes the serial master model and the design's constants header.
`include "flags_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic                 clk;
   logic                 rst_n;
   logic                 soft_rst;
   logic                 sck;
   logic                 cs_n;
   logic                 mosi;
   logic                 miso;
   logic                 oe;
   logic                 ro_rel;
   logic                 main_on;
   logic                 main_low;
   flags_pkg::events_s   ev;
   flags_pkg::dev_mode_e mode;
   logic [7:0]           lim;
   logic [7:0]           btm;
   logic [7:0]           raw;
   logic [7:0]           q;
   int                   n_mismatch = 0;
   int                   checks = 0;

   always #4 clk = ~clk;

   supply_thermal_flags dut (.CLK_I(clk), .RST_N_I(rst_n), .SOFT_RESET_I(soft_rst),
      .SPI_SCK_I(sck), .SPI_CS_N_I(cs_n), .SPI_MOSI_I(mosi), .EVENTS_I(ev), .MODE_I(mode),
      .MAIN_ON_I(main_on), .MAIN_LOW_I(main_low), .RESET_OUTPUT_RELEASED_I(ro_rel),
      .SPI_MISO_O(miso), .SPI_MISO_OE_O(oe), .RECOVERY_LOWER_LIMIT_O(lim),
      .BIT_TIME_MEASUREMENT_O(btm), .BIT_TIME_RAW_I(raw));

   spi_master_model master (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      master.xfer({a, 1'b1, d}, 16, q);
   endtask

   task automatic chk(input string what, input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] d;
      master.xfer({a, 1'b0, 8'h00}, 16, d);
      cmp(what, exp, d);
   endtask

   task automatic pulse(input logic [15:0] e);
      @(posedge clk) #1 ev = e;
      repeat (6) @(posedge clk);
      #1 ev = '0;
      repeat (4) @(posedge clk);
   endtask

   task automatic set_mode(input flags_pkg::dev_mode_e m, input logic on);
      @(posedge clk) #1 mode = m;
      main_on = on;
      repeat (4) @(posedge clk);
   endtask

   function automatic logic [23:0] expect_of(input logic [15:0] e);
      return {1'b0, e[15], 1'b0, e[14:10], 1'b0, e[9:3], 5'h00, e[2:0]};
   endfunction

   task automatic t_reset;
      chk("supply_a", `ADDR_SUPPLY_A, 8'h00);
      chk("supply_b", `ADDR_SUPPLY_B, 8'h80);
      chk("supply_b", `ADDR_SUPPLY_B, 8'h80);
      chk("thermal", `ADDR_THERMAL, 8'h00);
      chk("limit", `ADDR_LOWER_LIMIT, 8'h98);
      chk("unmapped", 7'h55, 8'h00);
      wr(`ADDR_SUPPLY_B, 8'h00);
      chk("supply_b", `ADDR_SUPPLY_B, 8'h00);
   endtask

   task automatic t_oe;
      logic [7:0] d;
      cmp("miso_oe", 8'h00, {7'h00, oe});
      fork
         master.xfer({`ADDR_THERMAL, 1'b0, 8'h00}, 16, d);
         begin
            #1000;
            cmp("miso_oe", 8'h01, {7'h00, oe});
         end
      join
      cmp("thermal", 8'h00, d);
      cmp("miso_oe", 8'h00, {7'h00, oe});
   endtask

   task automatic t_short;
      @(posedge clk) #1 main_low = 1'b1;
      chk("supply_b", `ADDR_SUPPLY_B, 8'h00);
      @(posedge clk) #1 main_low = 1'b0;
      repeat (4) @(posedge clk);
      chk("supply_b", `ADDR_SUPPLY_B, 8'h00);
   endtask

   task automatic t_gate;
      set_mode(flags_pkg::MODE_INIT, 1'b1);
      pulse(16'h0008);
      chk("supply_b", `ADDR_SUPPLY_B, 8'h00);
      @(posedge clk) #1 ro_rel = 1'b1;
      pulse(16'h0008);
      chk("supply_b", `ADDR_SUPPLY_B, 8'h01);
      wr(`ADDR_SUPPLY_B, 8'h00);
      set_mode(flags_pkg::MODE_RESTART, 1'b1);
      pulse(16'h0008);
      chk("supply_b", `ADDR_SUPPLY_B, 8'h00);
      set_mode(flags_pkg::MODE_SLEEP, 1'b0);
      pulse(16'h0808);
      chk("supply_a", `ADDR_SUPPLY_A, 8'h00);
      chk("supply_b", `ADDR_SUPPLY_B, 8'h00);
      set_mode(flags_pkg::MODE_STOP, 1'b1);
      pulse(16'h0008);
      chk("supply_b", `ADDR_SUPPLY_B, 8'h01);
      wr(`ADDR_SUPPLY_B, 8'h00);
      set_mode(flags_pkg::MODE_NORMAL, 1'b1);
   endtask

   task automatic t_map;
      logic [15:0] v;
      logic [23:0] e;
      for (int i = 0; i < 16; i++) begin
         v = 16'h0001 << i;
         e = expect_of(v);
         pulse(v);
         chk("supply_a", `ADDR_SUPPLY_A, e[23:16]);
         chk("supply_b", `ADDR_SUPPLY_B, e[15:8]);
         chk("thermal", `ADDR_THERMAL, e[7:0]);
         wr(i > 9 ? `ADDR_SUPPLY_A : i > 2 ? `ADDR_SUPPLY_B : `ADDR_THERMAL, 8'hFF);
      end
   endtask

   task automatic t_persist;
      @(posedge clk) #1 ev = 16'h0007;
      repeat (6) @(posedge clk);
      wr(`ADDR_THERMAL, 8'h00);
      chk("thermal", `ADDR_THERMAL, 8'h07);
      @(posedge clk) #1 ev = '0;
      master.xfer({`ADDR_THERMAL, 1'b1, 8'h00}, 8, q);
      chk("thermal", `ADDR_THERMAL, 8'h07);
      wr(`ADDR_THERMAL, 8'h00);
      chk("thermal", `ADDR_THERMAL, 8'h00);
   endtask

   task automatic t_limit;
      wr(`ADDR_LOWER_LIMIT, 8'h4C);
      chk("limit", `ADDR_LOWER_LIMIT, 8'h4C);
      cmp("limit_out", 8'h4C, lim);
      @(posedge clk) #1 raw = 8'h40;
      repeat (3) @(posedge clk);
      cmp("clamped", 8'h4C, btm);
      @(posedge clk) #1 raw = 8'h60;
      repeat (3) @(posedge clk);
      cmp("clamped", 8'h60, btm);
   endtask

   task automatic t_soft;
      pulse(16'h0601);
      @(posedge clk) #1 soft_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 soft_rst = 1'b0;
      repeat (4) @(posedge clk);
      chk("supply_a", `ADDR_SUPPLY_A, 8'h00);
      chk("supply_b", `ADDR_SUPPLY_B, 8'h00);
      chk("thermal", `ADDR_THERMAL, 8'h00);
      chk("limit", `ADDR_LOWER_LIMIT, 8'h98);
   endtask

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      soft_rst = 1'b0;
      ro_rel = 1'b0;
      main_on = 1'b1;
      main_low = 1'b0;
      ev = '0;
      mode = flags_pkg::MODE_NORMAL;
      raw = 8'h00;
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      t_reset;
      t_oe;
      t_gate;
      t_short;
      t_map;
      t_persist;
      t_limit;
      t_soft;
      summarize;
   end

   // About 100 frames of 2.2 us each; a hang is cut well past that
   initial begin
      #400000;
      n_mismatch++;
      summarize;
   end
endmodule
`default_nettype wire
